/* File: hdl/dsi_core.sv */
`timescale 1ns/1ps
`include "dsi_defines.svh"
module dsi_core import dsi_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cke,
  input wire logic [2:0] i_cmd,
  input wire logic i_bank_select_bit_zero,
  input wire logic i_bank_select_bit_one,
  input wire logic [12:0] i_address_lines,
  input wire logic [15:0] i_wdata,
  output logic o_wready,
  output logic [31:0] o_rdata_word,
  output logic o_rdata_valid,
  input wire logic i_rdata_ready,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe,
  output logic o_dqs_out,
  output logic o_dqs_oe,
  output logic [1:0] o_bank_q,
  output logic [12:0] o_row_q,
  output logic [9:0] o_column_q,
  output logic [2:0] o_burst_length_field,
  output logic o_burst_order_field,
  output logic [2:0] o_read_latency_field,
  output logic o_dll_enabled,
  output logic o_dll_reset_pulse,
  output logic o_all_idle,
  output logic o_init_done,
  output logic o_reserved_code,
  output logic o_early_access_err
);
  dsi_state_e state_q;
  dsi_state_e state_d;
  logic [12:0] burst_latency_config_q;
  logic [12:0] extended_config_register_q;
  logic [12:0] row_q [4];
  logic [1:0] bank_q;
  logic [9:0] col_q;
  logic [3:0] beat_q;
  logic [3:0] lat_cnt_q;
  logic [7:0] lock_q;
  logic [1:0] ref_q;
  logic dll_rst_q;
  logic err_q;
  logic rd_busy_q;
  logic [3:0] open_q;
  logic [2:0] col_lo;
  logic [15:0] burst_word;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;

  function automatic logic [3:0] beats_of(input logic [2:0] code);
    unique case (code)
      `DSI_BL2: beats_of = 4'h2;
      `DSI_BL4: beats_of = 4'h4;
      `DSI_BL8: beats_of = 4'h8;
      default: beats_of = 4'h0;
    endcase
  endfunction

  // Latency 2.5 counts as two whole clocks; the pins add no half clock either.
  function automatic logic [3:0] lat_of(input logic [2:0] code);
    unique case (code)
      `DSI_CL15: lat_of = 4'h1;
      `DSI_CL2: lat_of = 4'h2;
      `DSI_CL25: lat_of = 4'h2;
      `DSI_CL3: lat_of = 4'h3;
      default: lat_of = 4'h2;
    endcase
  endfunction

  wire [1:0] bank_in = {i_bank_select_bit_one, i_bank_select_bit_zero};
  wire [2:0] bl_code = burst_latency_config_q[`DSI_BL_LSB +: 3];
  wire bt_bit = burst_latency_config_q[`DSI_BT_BIT];
  wire [2:0] cl_code = burst_latency_config_q[`DSI_CL_LSB +: 3];
  wire [5:0] mode_bits = burst_latency_config_q[12:`DSI_MODE_LSB];
  wire [3:0] burst_beats = beats_of(bl_code);
  wire cmd_take = i_cke;
  wire is_load = cmd_take && i_cmd == DSI_CMD_LOAD;
  wire load_main = is_load && bank_in == 2'h0;
  wire load_ext = is_load && bank_in == 2'h1;
  wire dll_reset_req = load_main && i_address_lines[`DSI_DLLRST_BIT]
    && i_address_lines[7] == 1'b0
    && i_address_lines[12:9] == 4'h0;
  wire is_act = cmd_take && i_cmd == DSI_CMD_ACT;
  wire is_rd = cmd_take && i_cmd == DSI_CMD_RD;
  wire is_wr = cmd_take && i_cmd == DSI_CMD_WR;
  wire is_pre = cmd_take && i_cmd == DSI_CMD_PRE;
  wire is_ref = cmd_take && i_cmd == DSI_CMD_REF;
  wire pre_all = is_pre && i_address_lines[`DSI_PRE_ALL_BIT];
  wire access = is_rd || is_wr;
  wire [2:0] beat_mask = burst_beats == 4'h8 ? 3'h7 :
    burst_beats == 4'h4 ? 3'h3 : 3'h1;
  wire [2:0] beat_idx = beat_q[2:0];
  wire [2:0] start_lo = col_q[2:0];
  // Interleaved order flips address bits by beat; sequential adds beat.
  wire [2:0] seq_lo = start_lo + beat_idx;
  wire [2:0] ilv_lo = start_lo ^ beat_idx;
  wire [2:0] walk_lo = bt_bit ? ilv_lo : seq_lo;
  // Bits above the block come from the start address, so the burst
  // wraps inside its aligned block instead of running into the next one.
  assign col_lo = (start_lo & ~beat_mask) | (walk_lo & beat_mask);
  // Data word stands in for core contents: bank, row bits and column.
  assign burst_word = {bank_q, row_q[bank_q][3:0], col_q[9:3], col_lo};

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DSI_ST_POWERUP:
      begin
        if (load_ext)
        begin
          state_d = DSI_ST_EXT_DONE;
        end
      end
      DSI_ST_EXT_DONE:
      begin
        if (dll_reset_req)
        begin
          state_d = DSI_ST_LOCKING;
        end
      end
      // A precharge that comes before the lock count ends is ignored.
      DSI_ST_LOCKING:
      begin
        if (lock_q == `DSI_LOCK_CYCLES && pre_all)
        begin
          state_d = DSI_ST_IDLE_WAIT;
        end
      end
      DSI_ST_IDLE_WAIT:
      begin
        if (is_ref)
        begin
          state_d = DSI_ST_REFRESH;
        end
      end
      DSI_ST_REFRESH:
      begin
        if (ref_q == `DSI_REFRESH_NEEDED && load_main
          && !i_address_lines[`DSI_DLLRST_BIT])
        begin
          state_d = DSI_ST_READY;
        end
      end
      DSI_ST_READY: state_d = DSI_ST_READY;
      default: state_d = DSI_ST_POWERUP;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= DSI_ST_POWERUP;
      burst_latency_config_q <= `DSI_MAIN_RESET;
      extended_config_register_q <= `DSI_EXT_RESET;
      dll_rst_q <= 1'b0;
      lock_q <= 8'h0;
      ref_q <= 2'h0;
      err_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (load_main)
      begin
        burst_latency_config_q <= {i_address_lines[12:9], 1'b0,
          i_address_lines[7:0]};
      end
      if (load_ext)
      begin
        extended_config_register_q <= i_address_lines;
      end
      // The reset bit is never stored; this pulse is all that is left of it.
      dll_rst_q <= dll_reset_req;
      // The counter saturates, so a late precharge still ends the wait.
      if (dll_reset_req)
      begin
        lock_q <= 8'h0;
      end
      else if (lock_q != `DSI_LOCK_CYCLES)
      begin
        lock_q <= lock_q + 8'h1;
      end
      if (is_ref && ref_q != `DSI_REFRESH_NEEDED)
      begin
        ref_q <= ref_q + 2'h1;
      end
      // The flag is sticky so that software may look at it late.
      if (access && state_q != DSI_ST_READY)
      begin
        err_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int b = 0; b < 4; b++)
      begin
        row_q[b] <= 13'h0;
      end
      open_q <= 4'h0;
      bank_q <= 2'h0;
      col_q <= 10'h0;
      beat_q <= 4'h0;
      lat_cnt_q <= 4'h0;
      rd_busy_q <= 1'b0;
    end
    else
    begin
      // Rows are kept per bank so that a later access finds its open row.
      if (is_act)
      begin
        row_q[bank_in] <= i_address_lines;
        open_q[bank_in] <= 1'b1;
      end
      if (is_pre)
      begin
        open_q <= pre_all ? 4'h0 : open_q & ~(4'h1 << bank_in);
      end
      // A new access while a read is busy is dropped, not queued.
      if (access && state_q == DSI_ST_READY && !rd_busy_q)
      begin
        bank_q <= bank_in;
        col_q <= i_address_lines[9:0];
        beat_q <= 4'h0;
        lat_cnt_q <= lat_of(cl_code) - 4'h1;
        rd_busy_q <= is_rd;
      end
      else if (rd_busy_q)
      begin
        if (lat_cnt_q != 4'h0)
        begin
          lat_cnt_q <= lat_cnt_q - 4'h1;
        end
        else if (fifo_ready)
        begin
          beat_q <= beat_q + 4'h1;
          rd_busy_q <= beat_q + 4'h1 < burst_beats;
        end
      end
    end
  end

  wire drive_now = rd_busy_q && lat_cnt_q == 4'h0;
  // A write while a read burst is busy is ignored, like any new access.
  wire wr_push = is_wr && state_q == DSI_ST_READY && !rd_busy_q;
  // Pins are released whenever no read beat is on the bus.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_dq_out <= 8'h0;
      o_dq_oe <= 1'b0;
      o_dqs_out <= 1'b0;
      o_dqs_oe <= 1'b0;
    end
    else
    begin
      o_dq_oe <= drive_now && fifo_ready;
      o_dqs_oe <= drive_now && fifo_ready;
      o_dqs_out <= drive_now && fifo_ready && !beat_q[0];
      o_dq_out <= burst_word[7:0];
    end
  end

  // Core word pairs each FIFO entry with its inverse; FIFO absorbs back-pressure.
  dsi_fifo #(.WIDTH(16), .DEPTH(32)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(drive_now || wr_push),
    .o_ready(fifo_ready),
    .i_data(drive_now ? burst_word : i_wdata),
    .o_valid(fifo_valid),
    .i_ready(i_rdata_ready),
    .o_data(fifo_data)
  );

  assign o_rdata_word = {fifo_data, ~fifo_data};
  assign o_rdata_valid = fifo_valid;
  assign o_wready = fifo_ready;
  assign o_bank_q = bank_q;
  assign o_row_q = row_q[bank_q];
  assign o_column_q = col_q;
  assign o_burst_length_field = bl_code;
  assign o_burst_order_field = bt_bit;
  assign o_read_latency_field = cl_code;
  assign o_dll_enabled = !extended_config_register_q[`DSI_EXT_DLL_BIT];
  assign o_dll_reset_pulse = dll_rst_q;
  assign o_all_idle = open_q == 4'h0;
  assign o_init_done = state_q == DSI_ST_READY;
  // Reserved codes are only reported; the block still runs with them.
  assign o_reserved_code = burst_beats == 4'h0 || mode_bits != 6'h0
    || !(cl_code inside {`DSI_CL2, `DSI_CL3, `DSI_CL25, `DSI_CL15});
  assign o_early_access_err = err_q;
endmodule // dsi_core

/* File: hdl/dsi_defines.svh */
// What this block does
// - Four banks; Active takes bank from bank selects, row from address lines.
// - Each read beat moves one byte per core clock on the data pins as one whole transfer.
// - Read or Write address picks starting column within the opened row.
// - Data and strobe pins stay undriven until a read drives them.
// - Precharge all after locking puts device in all banks idle.
// - Load with both bank selects low writes main register, kept until reload.
// - DLL reset bit clears itself and is not retained.
// - Main register fields: length A0-A2, order A3, latency A4-A6, mode A7-A12.
// - Burst length codes 001, 010, 011 mean two, four, eight.
// - Order bit zero is sequential, one is interleaved.
// - Latency codes 010, 101, 110, optional 011; others reserved.
// - Operating mode all zeros is normal; others reserved.
// - Burst length applies to reads, writes and both orders as maximum; a write here pushes one word only.
// - Bursts wrap inside an aligned block as large as the burst.
// - Interleaved XORs start bits with beat; sequential increments modulo length.
// - First read data appears latency clocks after the read edge; here a half clock of latency is dropped.
// - Load with A8 set and other mode bits clear resets DLL, stores A0-A6.
// - Load with bank select zero high and bank select one low writes extended register; bit 0 DLL.
`ifndef DSI_DEFINES_SVH
`define DSI_DEFINES_SVH
`define DSI_BL_LSB 0
`define DSI_BT_BIT 3
`define DSI_CL_LSB 4
`define DSI_DLLRST_BIT 8
`define DSI_MODE_LSB 7
`define DSI_PRE_ALL_BIT 10
`define DSI_EXT_DLL_BIT 0
`define DSI_MAIN_RESET 13'h0000
`define DSI_EXT_RESET 13'h0001
`define DSI_BL2 3'h1
`define DSI_BL4 3'h2
`define DSI_BL8 3'h3
`define DSI_CL2 3'h2
`define DSI_CL3 3'h3
`define DSI_CL25 3'h5
`define DSI_CL15 3'h6
`define DSI_LOCK_CYCLES 8'hC8
`define DSI_REFRESH_NEEDED 2'h2
`endif

/* File: hdl/dsi_pkg.sv */
package dsi_pkg;
  typedef enum logic [2:0] {
    DSI_CMD_NOP = 3'h7,
    DSI_CMD_ACT = 3'h3,
    DSI_CMD_RD = 3'h5,
    DSI_CMD_WR = 3'h4,
    DSI_CMD_PRE = 3'h2,
    DSI_CMD_REF = 3'h1,
    DSI_CMD_LOAD = 3'h0
  } dsi_cmd_e;
  typedef enum logic [2:0] {
    DSI_ST_POWERUP = 3'h0,
    DSI_ST_EXT_DONE = 3'h1,
    DSI_ST_LOCKING = 3'h3,
    DSI_ST_IDLE_WAIT = 3'h2,
    DSI_ST_REFRESH = 3'h6,
    DSI_ST_READY = 3'h7
  } dsi_state_e;
endpackage

/* File: hdl/dsi_fifo.sv */
`timescale 1ns/1ps
module dsi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  assign o_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rd_q];
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_data;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // dsi_fifo

/* File: tb/dsi_checker.sv */
`timescale 1ns/1ps
module dsi_checker import dsi_pkg::*; (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cke,
  input wire logic [2:0] i_cmd,
  input wire logic i_bank_select_bit_zero,
  input wire logic i_bank_select_bit_one,
  input wire logic [12:0] i_address_lines,
  input wire logic o_dq_oe,
  input wire logic o_dqs_oe,
  input wire logic [1:0] o_bank_q,
  input wire logic [12:0] o_row_q,
  input wire logic [2:0] o_burst_length_field,
  input wire logic o_burst_order_field,
  input wire logic [2:0] o_read_latency_field,
  input wire logic o_dll_enabled,
  input wire logic o_dll_reset_pulse,
  input wire logic o_init_done,
  input wire logic o_early_access_err
);
  wire logic [1:0] ba = {i_bank_select_bit_one, i_bank_select_bit_zero};
  wire logic [12:0] a = i_address_lines;
  wire logic ld = i_cke && i_cmd == DSI_CMD_LOAD;
  wire logic ld_main = ld && ba == 2'h0;
  wire logic ld_dll = ld_main && a[8] && !a[7] && a[12:9] == 4'h0;
  wire logic act = i_cke && i_cmd == DSI_CMD_ACT && o_init_done;
  wire logic acc = i_cke && (i_cmd == DSI_CMD_RD || i_cmd == DSI_CMD_WR);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Only a read issued at latency code 010 while the data pins are quiet is asked for the exact latency.
  sequence rd_cl2_s;
    acc && i_cmd == DSI_CMD_RD && o_init_done && !o_dq_oe &&
      o_read_latency_field == 3'h2;
  endsequence
  sequence beat_s;
    !o_dq_oe ##1 o_dq_oe;
  endsequence
  // The bank is taken as access target once the read follows the active.
  sequence act_rd_s;
    act ##1 !act ##1 acc && ba == $past(ba, 2);
  endsequence
  main_fields_a: assert property (ld_main |=>
    o_burst_length_field == $past(a[2:0]) &&
    o_burst_order_field == $past(a[3]) &&
    o_read_latency_field == $past(a[6:4]))
    else $error("main fields not loaded");
  main_hold_a: assert property (!ld_main |=>
    $stable(o_burst_length_field) && $stable(o_read_latency_field))
    else $error("main fields changed without load");
  dll_pulse_a: assert property (ld_dll |=>
    o_dll_reset_pulse ##1 !o_dll_reset_pulse)
    else $error("dll reset pulse wrong");
  no_pulse_a: assert property (!ld_dll |=> !o_dll_reset_pulse)
    else $error("dll reset pulse without cause");
  ext_dll_a: assert property (ld && ba == 2'h1 |=>
    o_dll_enabled == !$past(a[0]))
    else $error("dll enable not loaded");
  early_err_a: assert property (acc && !o_init_done |=>
    o_early_access_err)
    else $error("early access not flagged");
  err_hold_a: assert property (o_early_access_err |=>
    o_early_access_err)
    else $error("error flag dropped");
  act_cap_a: assert property (act_rd_s |=>
    o_bank_q == $past(ba) && o_row_q == $past(a, 3))
    else $error("active target not captured");
  quiet_pins_a: assert property (!o_init_done |->
    !o_dq_oe && !o_dqs_oe)
    else $error("data pins driven before init");
  read_lat_a: assert property (rd_cl2_s |-> ##2 beat_s)
    else $error("read data not at latency two");
endmodule // dsi_checker
bind dsi_core dsi_checker chk_u (.i_clk, .i_reset_n, .i_cke, .i_cmd,
  .i_bank_select_bit_zero, .i_bank_select_bit_one, .i_address_lines,
  .o_dq_oe, .o_dqs_oe, .o_bank_q, .o_row_q, .o_burst_length_field,
  .o_burst_order_field, .o_read_latency_field, .o_dll_enabled,
  .o_dll_reset_pulse, .o_init_done, .o_early_access_err);

/* File: tb/dsi_ctrl_model.sv */
`timescale 1ns/1ps
module dsi_ctrl_model import dsi_pkg::*; #(
  parameter int POWERUP_CYCLES = 4000
) (
  input wire logic i_clk,
  output logic o_cke,
  output logic [2:0] o_cmd,
  output logic o_bs0,
  output logic o_bs1,
  output logic [12:0] o_addr
);
  initial
  begin
    o_cke = 1'b0;
    o_cmd = DSI_CMD_NOP;
    {o_bs1, o_bs0} = 2'h0;
    o_addr = 13'h0000;
  end
  // Between commands the address shows the inverse of the last value.
  task automatic issue(input dsi_cmd_e c, input logic [1:0] b,
    input logic [12:0] a);
    @(negedge i_clk);
    o_cmd = c;
    {o_bs1, o_bs0} = b;
    o_addr = a;
    @(negedge i_clk);
    o_cmd = DSI_CMD_NOP;
    o_addr = ~a;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic init_seq(input logic [6:0] op);
    o_cke = 1'b0;
    idle(POWERUP_CYCLES);
    o_cke = 1'b1;
    issue(DSI_CMD_PRE, 2'h0, 13'h0400);
    issue(DSI_CMD_LOAD, 2'h1, 13'h0000);
    issue(DSI_CMD_LOAD, 2'h0, {6'h02, op});
    idle(200);
    issue(DSI_CMD_PRE, 2'h0, 13'h0400);
    issue(DSI_CMD_REF, 2'h0, 13'h0000);
    issue(DSI_CMD_REF, 2'h0, 13'h0000);
    issue(DSI_CMD_LOAD, 2'h0, {6'h00, op});
  endtask
endmodule // dsi_ctrl_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import dsi_pkg::*; ;
  logic i_clk, i_reset_n, i_cke, i_bank_select_bit_zero;
  logic i_bank_select_bit_one, i_rdata_ready, o_wready, o_rdata_valid;
  logic o_dq_oe, o_dqs_oe, o_burst_order_field, o_dll_enabled, o_all_idle;
  logic o_dll_reset_pulse, o_init_done, o_reserved_code, o_early_access_err;
  logic [2:0] i_cmd, o_burst_length_field, o_read_latency_field;
  logic [12:0] i_address_lines, o_row_q, a;
  logic [15:0] i_wdata;
  logic [31:0] o_rdata_word;
  logic [1:0] o_bank_q;
  logic [9:0] o_column_q;
  logic [7:0] o_dq_out;
  logic o_dqs_out;
  logic [6:0] op;
  logic [2:0] cls [5] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h4};
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 19097;
  int n;
  dsi_core dut_u (.i_clk, .i_reset_n, .i_cke, .i_cmd,
    .i_bank_select_bit_zero, .i_bank_select_bit_one, .i_address_lines,
    .i_wdata, .o_wready, .o_rdata_word, .o_rdata_valid, .i_rdata_ready,
    .o_dq_out, .o_dq_oe, .o_dqs_out, .o_dqs_oe, .o_bank_q, .o_row_q,
    .o_column_q, .o_burst_length_field, .o_burst_order_field,
    .o_read_latency_field, .o_dll_enabled, .o_dll_reset_pulse, .o_all_idle,
    .o_init_done, .o_reserved_code, .o_early_access_err);
  dsi_ctrl_model ctrl_u (.i_clk, .o_cke(i_cke), .o_cmd(i_cmd),
    .o_bs0(i_bank_select_bit_zero), .o_bs1(i_bank_select_bit_one),
    .o_addr(i_address_lines));
  function automatic int lat_of(input logic [2:0] c);
    return c == 3'h6 ? 1 : c == 3'h3 ? 3 : 2;
  endfunction
  function automatic logic resv(input logic [2:0] b, input logic [2:0] c);
    return !(b inside {3'h1, 3'h2, 3'h3}) ||
      !(c inside {3'h2, 3'h3, 3'h5, 3'h6});
  endfunction
  // Low column bits of beat k in a burst of four, wrapping in its block.
  function automatic logic [2:0] burst_lo(input logic [2:0] s,
    input logic [2:0] k, input logic il);
    logic [1:0] w;
    w = il ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0];
    return {s[2], w};
  endfunction
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    i_reset_n = 1'b0;
    i_wdata = 16'h0000;
    i_rdata_ready = 1'b1;
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    ctrl_u.init_seq(7'h22);
    check(o_init_done === 1'b1, "init not done");
    check(o_dll_enabled === 1'b1, "dll not enabled");
    $display("init test ended");
    foreach (cls[i])
      for (int b = 0; b < 4; b++)
      begin
        op = {cls[i], 1'($random(seed)), 3'(b)};
        ctrl_u.issue(DSI_CMD_LOAD, 2'h0, {6'h00, op});
        check(o_burst_length_field === op[2:0], "length field");
        check(o_burst_order_field === op[3], "order field");
        check(o_read_latency_field === op[6:4], "latency field");
        check(o_reserved_code === resv(op[2:0], op[6:4]), "reserved");
      end
    ctrl_u.issue(DSI_CMD_LOAD, 2'h0, 13'h00A2);
    check(o_reserved_code === 1'b1, "mode not reserved");
    ctrl_u.issue(DSI_CMD_LOAD, 2'h0, 13'h0122);
    check(o_reserved_code === 1'b0, "dll reset reserved");
    ctrl_u.idle(200);
    $display("config test ended");
    for (int i = 0; i < 4; i++)
    begin
      ctrl_u.issue(DSI_CMD_LOAD, 2'h0, {6'h00, cls[i], 1'(i), 3'h2});
      a = 13'($random(seed));
      ctrl_u.issue(DSI_CMD_ACT, a[12:11], a);
      ctrl_u.issue(DSI_CMD_RD, a[12:11], {3'h0, a[9:0]});
      check(o_bank_q === a[12:11] && o_row_q === a, "target");
      check(o_column_q === a[9:0], "column");
      n = 0;
      while (o_dq_oe !== 1'b1 && n < 10)
      begin
        @(negedge i_clk);
        n++;
      end
      check(n == lat_of(cls[i]), "read latency");
      for (int k = 0; k < 4; k++)
      begin
        check(o_dq_oe === 1'b1 && o_dqs_oe === 1'b1, "beat gap");
        check(o_dq_out === {a[7:3], burst_lo(a[2:0], 3'(k), i[0])},
          "burst order");
        check(o_dqs_out === !k[0], "strobe");
        @(negedge i_clk);
      end
      check(o_dq_oe === 1'b0, "burst too long");
      ctrl_u.issue(DSI_CMD_PRE, 2'h0, 13'h0400);
      check(o_all_idle === 1'b1, "banks not idle");
      ctrl_u.idle(8);
    end
    $display("latency test ended");
    ctrl_u.issue(DSI_CMD_ACT, 2'h0, 13'h0000);
    i_rdata_ready = 1'b0;
    n = 0;
    while (o_wready === 1'b1 && n < 100)
    begin
      i_wdata = 16'($random(seed));
      ctrl_u.issue(n % 2 ? DSI_CMD_WR : DSI_CMD_RD, 2'h0, 13'h0000);
      n++;
    end
    check(o_wready === 1'b0, "buffer never full");
    i_rdata_ready = 1'b1;
    n = 0;
    while (o_rdata_valid === 1'b1 && n < 100)
    begin
      check(o_rdata_word[31:16] === ~o_rdata_word[15:0], "pairing");
      @(negedge i_clk);
      n++;
    end
    check(n >= 32 && o_rdata_valid === 1'b0, "drain count");
    $display("buffer test ended");
    i_reset_n = 1'b0;
    @(negedge i_clk);
    i_reset_n = 1'b1;
    check(o_all_idle === 1'b1 && o_dll_enabled === 1'b0, "reset");
    ctrl_u.issue(DSI_CMD_RD, 2'h0, 13'h0005);
    ctrl_u.idle(4);
    check(o_early_access_err === 1'b1, "early read");
    check(o_dq_oe === 1'b0, "pins driven");
    $display("early access test ended");
    tally_and_finish;
  end
endmodule // tb_top
